// File: hdl/eso_pkg.sv
`default_nettype none
package eso_pkg;

  // parameter addresses
  localparam logic [15:0] ADDR_PULSE_RES = 16'h052A;
  localparam logic [15:0] ADDR_FINE_RES = 16'h0564;
  localparam logic [15:0] ADDR_PHASE_OFS = 16'h0566;

  // reset values and legal ranges
  localparam logic [15:0] PULSE_RES_RST = 16'h1000;
  localparam logic [15:0] PULSE_RES_MIN = 16'h0008;
  localparam logic [31:0] FINE_RES_RST = 32'h0000_0000;
  localparam logic [31:0] FINE_RES_MAX = 32'h0FFF_F000;
  localparam logic [31:0] FINE_OFF = 32'h0000_0000;
  localparam logic signed [15:0] PHASE_RST = 16'sh0000;

  // fixed point layout
  localparam int FRAC_BITS = 12;
  localparam int POS_FRAC_BITS = 16;
  localparam logic [11:0] FRAC_ZERO = 12'h000;
  localparam logic [31:0] PERIOD_MIN = 32'h0000_0001;

  // index placement inside a turn
  localparam logic [31:0] IDX_WINDOW = 32'h0000_0004;
  localparam logic [1:0] IDX_AB_STATE = 2'h2;

  // retention store words
  localparam int NV_WORDS = 2;
  localparam logic MEM_IDX_RES = 1'h0;
  localparam logic MEM_IDX_FINE = 1'h1;

  typedef enum logic [1:0] {
    BOOT_RES = 2'b00,
    BOOT_FINE = 2'b01,
    BOOT_LAST = 2'b10,
    RUN = 2'b11
  } eso_boot_e;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_RES = 2'b01,
    SEL_FINE = 2'b10,
    SEL_PHASE = 2'b11
  } eso_sel_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } eso_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } eso_rsp_s;

  function automatic eso_sel_e eso_decode(input logic [15:0] addr);
    eso_sel_e sel;
    sel = SEL_NONE;
    if (addr == ADDR_PULSE_RES) sel = SEL_RES;
    if (addr == ADDR_FINE_RES) sel = SEL_FINE;
    if (addr == ADDR_PHASE_OFS) sel = SEL_PHASE;
    return sel;
  endfunction

  // quadrature state {a, b}: 00, 10, 11, 01 counting up
  function automatic logic [1:0] eso_ab(input logic [1:0] ph);
    return {ph[1] ^ ph[0], ph[1]};
  endfunction

endpackage
`default_nettype wire

// File: hdl/eso_nvmem.sv
`default_nettype none
module eso_nvmem
  import eso_pkg::*;
(
  // clock, restore, enable
  input wire logic core_clk,
  input wire logic nv_reset,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic wr_idx,
  input wire logic [31:0] wdata,
  // read port
  input wire logic rd_idx,
  output logic [31:0] rdata
);

  logic [31:0] mem_r [NV_WORDS];

  // survives the power-on reset; only a factory restore reloads the reset values
  always_ff @(posedge core_clk or posedge nv_reset) begin
    if (nv_reset) begin
      mem_r[MEM_IDX_RES] <= {16'h0000, PULSE_RES_RST};
      mem_r[MEM_IDX_FINE] <= FINE_RES_RST;
    end else if (ce && we) begin
      mem_r[wr_idx] <= wdata;
    end
  end

  always_ff @(posedge core_clk or posedge nv_reset) begin
    if (nv_reset) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= mem_r[rd_idx];
    end
  end

endmodule // eso_nvmem
`default_nettype wire

// File: hdl/eso_quad.sv
`default_nettype none
module eso_quad
  import eso_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // position demand
  input wire logic run,
  input wire logic [31:0] target,
  input wire logic [31:0] period,
  // pulse train
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic [31:0] count
);

  logic [31:0] rev_r;
  logic [31:0] count_nxt;
  logic [31:0] rev_nxt;
  logic [31:0] diff;
  logic [1:0] ab_nxt;

  // one increment per clock at most; wrap-safe signed distance
  always_comb begin
    diff = target - count;
    count_nxt = count;
    rev_nxt = rev_r;
    if (run && diff != 32'h0) begin
      if (!diff[31]) begin
        count_nxt = count + 32'h1;
        rev_nxt = (rev_r >= period - 32'h1) ? 32'h0 : rev_r + 32'h1;
      end else begin
        count_nxt = count - 32'h1;
        rev_nxt = (rev_r == 32'h0) ? period - 32'h1 : rev_r - 32'h1;
      end
    end
    ab_nxt = eso_ab(count_nxt[1:0]);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      rev_r <= 32'h0;
    end else if (ce) begin
      count <= count_nxt;
      rev_r <= rev_nxt;
    end
  end

  // index: the single A&B-high state in the first four steps of a turn
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enc_a <= 1'b0;
      enc_b <= 1'b0;
      enc_index <= 1'b0;
    end else if (ce) begin
      enc_a <= ab_nxt[1];
      enc_b <= ab_nxt[0];
      enc_index <= (rev_nxt < IDX_WINDOW) &&
                   (count_nxt[1:0] == IDX_AB_STATE);
    end
  end

  a_pins_track: assert property (@(posedge core_clk) disable iff (reset)
    {enc_a, enc_b} == eso_ab(count[1:0]))
    else $error("quadrature pins disagree with count");

  a_fwd_lag: assert property (@(posedge core_clk) disable iff (reset)
    (count == $past(count) + 32'h1) && $rose(enc_a) |-> !enc_b)
    else $error("B not lagging A in forward motion");

  a_index_ab: assert property (@(posedge core_clk) disable iff (reset)
    enc_index |-> enc_a && enc_b && rev_r < IDX_WINDOW)
    else $error("index outside the A and B high state");

  a_one_step: assert property (@(posedge core_clk) disable iff (reset)
    $countones({enc_a, enc_b} ^ $past({enc_a, enc_b})) <= 1)
    else $error("A and B changed together");

endmodule // eso_quad
`default_nettype wire

// File: hdl/eso_top.sv
`default_nettype none
module eso_top
  import eso_pkg::*;
(
  // clock, power-on reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // factory restore of the retained settings
  input wire logic nv_reset,
  // drive state
  input wire logic power_stage_en,
  // motor motion per clock, 1/65536 turn units
  input wire logic signed [15:0] pos_step,
  // parameter access
  input wire eso_req_s par_req,
  output eso_rsp_s par_rsp,
  // pulse train output
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  // status
  output logic fine_mode,
  output logic run
);

  eso_boot_e state_r;
  eso_boot_e state_nxt;
  logic [15:0] act_res_r;
  logic [31:0] act_fine_r;
  logic signed [15:0] phase_r;
  logic signed [63:0] acc_r;
  logic [31:0] res_fix;
  logic [31:0] period;
  logic signed [48:0] prod;
  logic signed [63:0] pos_q12;
  logic [31:0] target;
  logic is_running;
  logic mem_we;
  logic mem_wr_idx;
  logic mem_rd_idx;
  logic [31:0] mem_rdata;
  logic req_take;
  eso_sel_e req_sel;
  logic req_bad;
  logic [15:0] req_wlo;
  logic pend_r;
  logic pend_err_r;
  eso_sel_e pend_sel_r;

  assign is_running = (state_r == RUN);

  // power-on sequence: fetch the retained settings once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BOOT_RES: begin
        state_nxt = BOOT_FINE;
      end
      BOOT_FINE: begin
        state_nxt = BOOT_LAST;
      end
      BOOT_LAST: begin
        state_nxt = RUN;
      end
      RUN: begin
        state_nxt = RUN;
      end
      default: begin
        state_nxt = BOOT_RES;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= BOOT_RES;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // active copies load only during boot, so later writes wait for power-on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      act_res_r <= PULSE_RES_RST;
      act_fine_r <= FINE_RES_RST;
    end else if (ce) begin
      if (state_r == BOOT_FINE) begin
        act_res_r <= mem_rdata[15:0];
      end
      if (state_r == BOOT_LAST) begin
        act_fine_r <= mem_rdata;
      end
    end
  end

  // increments per turn scaled by 4096; integer setting only when fine is 0
  assign res_fix = (act_fine_r != FINE_OFF) ? act_fine_r :
                   32'({act_res_r, FRAC_ZERO});

  // pulses between index marks: the integer setting, or the whole part of the fine value when fine is not 0
  always_comb begin
    if (act_fine_r == FINE_OFF) begin
      period = {16'h0000, act_res_r};
    end else begin
      period = act_fine_r >> FRAC_BITS;
    end
    // a fine value below one pulse per turn still needs a period
    if (period == 32'h0) begin
      period = PERIOD_MIN;
    end
  end

  // motor motion times resolution accumulates in 2^-28 pulse units
  assign prod = pos_step * $signed({1'b0, res_fix});

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_r <= 64'sh0;
    end else if (ce && is_running) begin
      acc_r <= acc_r + 64'(prod);
    end
  end

  // phase offset adds in 1/4096 pulse units, ahead of the pulse count
  assign pos_q12 = (acc_r >>> POS_FRAC_BITS) + 64'(phase_r);
  assign target = pos_q12[FRAC_BITS +: 32];

  // parameter requests: taken one at a time, answered two edges later;
  // not taken while ack shows, so a master that holds until it sees ack
  // is never served twice
  assign req_take = ce && is_running && !pend_r && !par_rsp.ack &&
                    (par_req.wr || par_req.rd);
  assign req_sel = eso_decode(par_req.addr);
  assign req_wlo = par_req.wdata[15:0];

  always_comb begin
    req_bad = 1'b0;
    case (req_sel)
      SEL_NONE: begin
        req_bad = 1'b1;
      end
      SEL_RES: begin
        req_bad = par_req.wr && (power_stage_en ||
                  par_req.wdata[31:16] != 16'h0000 ||
                  req_wlo < PULSE_RES_MIN);
      end
      SEL_FINE: begin
        req_bad = par_req.wr && (power_stage_en ||
                  par_req.wdata > FINE_RES_MAX);
      end
      SEL_PHASE: begin
        req_bad = 1'b0;
      end
      default: begin
        req_bad = 1'b1;
      end
    endcase
  end

  // refused writes never reach the store
  assign mem_we = req_take && par_req.wr && !req_bad &&
                  (req_sel != SEL_PHASE);
  assign mem_wr_idx = (req_sel == SEL_FINE) ? MEM_IDX_FINE : MEM_IDX_RES;

  always_comb begin
    case (state_r)
      BOOT_RES: begin
        mem_rd_idx = MEM_IDX_RES;
      end
      BOOT_FINE: begin
        mem_rd_idx = MEM_IDX_FINE;
      end
      default: begin
        mem_rd_idx = mem_wr_idx;
      end
    endcase
  end

  eso_nvmem u_nvmem (
    .core_clk(core_clk),
    .nv_reset(nv_reset),
    .ce(ce),
    .we(mem_we),
    .wr_idx(mem_wr_idx),
    .wdata(par_req.wdata),
    .rd_idx(mem_rd_idx),
    .rdata(mem_rdata)
  );

  // the phase offset is not retained and applies on the next edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_r <= PHASE_RST;
    end else if (req_take && par_req.wr && req_sel == SEL_PHASE) begin
      phase_r <= req_wlo;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_r <= 1'b0;
      pend_err_r <= 1'b0;
      pend_sel_r <= SEL_NONE;
    end else if (ce) begin
      pend_r <= req_take;
      if (req_take) begin
        pend_err_r <= req_bad;
        pend_sel_r <= req_sel;
      end
    end
  end

  // resolution reads show the stored value, not the one in use
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      par_rsp <= '0;
    end else if (ce) begin
      par_rsp.ack <= pend_r;
      par_rsp.err <= pend_r && pend_err_r;
      if (pend_r) begin
        case (pend_sel_r)
          SEL_RES: begin
            par_rsp.rdata <= {16'h0000, mem_rdata[15:0]};
          end
          SEL_FINE: begin
            par_rsp.rdata <= mem_rdata;
          end
          SEL_PHASE: begin
            par_rsp.rdata <= 32'(phase_r);
          end
          default: begin
            par_rsp.rdata <= 32'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fine_mode <= 1'b0;
      run <= 1'b0;
    end else if (ce) begin
      fine_mode <= (act_fine_r != FINE_OFF);
      run <= is_running;
    end
  end

  eso_quad u_quad (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .run(is_running),
    .target(target),
    .period(period),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_index(enc_index),
    .count()
  );

  sequence s_live_res_wr;
    req_take && par_req.wr && power_stage_en &&
    (req_sel == SEL_RES || req_sel == SEL_FINE) ##1 ce;
  endsequence

  sequence s_fine_high;
    req_take && par_req.wr && req_sel == SEL_FINE &&
    par_req.wdata > FINE_RES_MAX ##1 ce;
  endsequence

  sequence s_res_low;
    req_take && par_req.wr && req_sel == SEL_RES &&
    req_wlo < PULSE_RES_MIN ##1 ce;
  endsequence

  sequence s_boot;
    state_r == BOOT_RES && ce ##1 ce ##1 ce;
  endsequence

  a_res_locked: assert property (@(posedge core_clk) disable iff (reset)
    s_live_res_wr |=> par_rsp.ack && par_rsp.err)
    else $error("resolution write accepted while powered");

  a_fine_range: assert property (@(posedge core_clk) disable iff (reset)
    s_fine_high |=> par_rsp.err)
    else $error("fine resolution above range accepted");

  a_int_range: assert property (@(posedge core_clk) disable iff (reset)
    s_res_low |=> par_rsp.err)
    else $error("integer resolution below range accepted");

  a_phase_now: assert property (@(posedge core_clk) disable iff (reset)
    req_take && par_req.wr && req_sel == SEL_PHASE
    |=> phase_r == $past(req_wlo))
    else $error("phase offset not applied at once");

  a_cfg_frozen: assert property (@(posedge core_clk) disable iff (reset)
    is_running |=> $stable(act_res_r) && $stable(act_fine_r))
    else $error("active resolution changed while running");

  a_boot_run: assert property (@(posedge core_clk) disable iff (reset)
    s_boot |=> is_running)
    else $error("boot did not reach run in three enabled edges");

  a_mode_pick: assert property (@(posedge core_clk) disable iff (reset)
    is_running && ce ##1 act_fine_r == FINE_OFF |=> !fine_mode)
    else $error("fine mode shown while fine value is zero");

  a_ok_write: assert property (@(posedge core_clk) disable iff (reset)
    req_take && par_req.wr && !power_stage_en && req_sel == SEL_FINE &&
    par_req.wdata <= FINE_RES_MAX ##1 ce |=> par_rsp.ack && !par_rsp.err)
    else $error("legal fine write refused with stage off");

endmodule // eso_top
`default_nettype wire

// File: dv/eso_ctl_model.sv
`default_nettype none
module eso_ctl_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pulse train from the drive
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  // counter state
  output logic signed [31:0] pos_cnt,
  output logic [15:0] idx_cnt,
  output logic [15:0] bad_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  logic idx_r;
  logic [1:0] ph;
  logic [1:0] dlt;
  assign ph = {enc_b, enc_a ^ enc_b};
  assign dlt = ph - ph_r;
  // a skipped quadrature state cannot be counted either way
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ph_r <= 2'h0;
      idx_r <= 1'b0;
      pos_cnt <= 32'sh0;
      idx_cnt <= 16'h0;
      bad_cnt <= 16'h0;
    end else begin
      ph_r <= ph;
      idx_r <= enc_index;
      if (dlt == 2'h1) pos_cnt <= pos_cnt + 32'sh1;
      if (dlt == 2'h3) pos_cnt <= pos_cnt - 32'sh1;
      if (enc_index && !idx_r) idx_cnt <= idx_cnt + 16'h1;
      if (dlt == 2'h2 || (enc_index && !(enc_a && enc_b))) begin
        bad_cnt <= bad_cnt + 16'h1;
      end
    end
  end
endmodule // eso_ctl_model
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
  import eso_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, ce, nv_reset, power_stage_en, fine_mode, run;
  logic signed [15:0] pos_step;
  eso_req_s par_req;
  eso_rsp_s par_rsp;
  logic enc_a, enc_b, enc_index, e;
  logic signed [31:0] pos_cnt;
  logic [15:0] idx_cnt, bad_cnt;
  logic [31:0] q;
  int error_cnt, n_compared, n;
  longint sum, base;
  eso_top uut (.core_clk(core_clk), .reset(reset), .ce(ce),
    .nv_reset(nv_reset), .power_stage_en(power_stage_en),
    .pos_step(pos_step), .par_req(par_req), .par_rsp(par_rsp),
    .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index),
    .fine_mode(fine_mode), .run(run));
  eso_ctl_model ctl (.core_clk(core_clk), .reset(reset), .enc_a(enc_a),
    .enc_b(enc_b), .enc_index(enc_index), .pos_cnt(pos_cnt),
    .idx_cnt(idx_cnt), .bad_cnt(bad_cnt));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic hang;
    error_cnt++;
    stop_test();
  endtask
  // counts reached per turn: resolution in 1/4096 steps, 16-bit turn
  function automatic longint exp_cnt(input longint s, input longint rx);
    return (s * rx) >>> 28;
  endfunction
  task automatic do_reset;
    int k;
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    tick(1);
    check(run, 1'b0);
    for (k = 0; k < 20 && run !== 1'b1; k++) tick(1);
    if (run !== 1'b1) hang();
    check(k, 32'h3);
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int k;
    par_req = '{wr: w, rd: !w, addr: a, wdata: d};
    for (k = 0; k < 10; k++) begin
      @(posedge core_clk);
      if (par_rsp.ack === 1'b1) break;
    end
    if (k == 10) hang();
    e = par_rsp.err;
    q = par_rsp.rdata;
    #1;
    par_req = '0;
    tick(3);
  endtask
  task automatic settle(input longint exp);
    int k;
    for (k = 0; k < 1000 && pos_cnt !== 32'(exp); k++) tick(1);
    check(pos_cnt, 32'(exp));
    if (pos_cnt !== 32'(exp)) hang();
  endtask
  task automatic move(input int k, input logic signed [15:0] st,
                      input longint exp);
    pos_step = st;
    tick(k);
    pos_step = 16'sh0;
    settle(exp);
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    nv_reset = 1'b1;
    power_stage_en = 1'b0;
    pos_step = 16'sh0;
    par_req = '0;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'h8dda));
    tick(1);
    nv_reset = 1'b0;
    do_reset();
    acc(1'b0, ADDR_PULSE_RES, 32'h0);
    check(q, 32'h0000_1000);
    acc(1'b0, ADDR_FINE_RES, 32'h0);
    check(q, 32'h0);
    acc(1'b0, ADDR_PHASE_OFS, 32'h0);
    check(q, 32'h0);
    acc(1'b0, 16'h0000, 32'h0);
    check(e, 1'b1);
    check(fine_mode, 1'b0);
    sum = 0;
    repeat (6) begin
      n = $urandom_range(20, 1);
      pos_step = $urandom_range(1, 0) ? 16'sh0100 : -16'sh0100;
      sum += n * pos_step;
      move(n, pos_step, exp_cnt(sum, 64'h100_0000));
    end
    base = exp_cnt(sum, 64'h100_0000);
    acc(1'b1, ADDR_PHASE_OFS, 32'h0000_1000);
    settle(base + 1);
    acc(1'b1, ADDR_PHASE_OFS, 32'h0000_8000);
    settle(base - 8);
    acc(1'b0, ADDR_PHASE_OFS, 32'h0);
    check(q, 32'hFFFF_8000);
    power_stage_en = 1'b1;
    acc(1'b1, ADDR_PULSE_RES, 32'h0000_0008);
    check(e, 1'b1);
    acc(1'b1, ADDR_FINE_RES, 32'h0000_8000);
    check(e, 1'b1);
    acc(1'b1, ADDR_PHASE_OFS, 32'h0);
    check(e, 1'b0);
    settle(base);
    power_stage_en = 1'b0;
    acc(1'b0, ADDR_PULSE_RES, 32'h0);
    check(q, 32'h0000_1000);
    acc(1'b1, ADDR_PULSE_RES, 32'h0000_0007);
    check(e, 1'b1);
    acc(1'b1, ADDR_PULSE_RES, 32'h0001_0010);
    check(e, 1'b1);
    acc(1'b1, ADDR_FINE_RES, 32'h0FFF_F001);
    check(e, 1'b1);
    acc(1'b1, ADDR_FINE_RES, 32'h0FFF_F000);
    acc(1'b0, ADDR_FINE_RES, 32'h0);
    check(q, 32'h0FFF_F000);
    check(fine_mode, 1'b0);
    acc(1'b1, ADDR_FINE_RES, 32'h0);
    acc(1'b1, ADDR_PULSE_RES, 32'h0000_0008);
    check(e, 1'b0);
    move(1, 16'sh0100, base + 16);
    do_reset();
    move(256, 16'sh0100, 8);
    check(idx_cnt, 16'h1);
    acc(1'b1, ADDR_FINE_RES, 32'h0000_8000);
    do_reset();
    check(fine_mode, 1'b1);
    move(512, 16'sh0100, 16);
    check(idx_cnt, 16'h2);
    acc(1'b1, ADDR_FINE_RES, 32'h0000_8C00);
    do_reset();
    move(1024, 16'sh0100, 35);
    check(idx_cnt, 16'h5);
    check(bad_cnt, 16'h0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
